// ### logic/tcc_map.svh
// Constants for the timer/counter base counter and capture channels
// Behaviour
// R1 - Prescaler taps divide-by-1 up to divide-by-1024 are directly selectable count sources.
// R2 - Count source selection picks one prescaler tap or one event channel.
// R3 - Software selects an event channel as count source for event-action counting.
// R4 - After reset no count source is selected and the counter stays stopped.
// R5 - Compare use: buffer write sets valid flag; update copy clears it.
// R6 - Capture use: the capture event sets the channel buffer valid flag.
// R7 - Capture buffer and channel register form a two-deep queue raising the channel flag.
// R8 - Channel registers and channel buffers are directly writable and readable.
// R9 - Counting up, after top the next count clock makes the counter zero.
// R10 - Counting down, at zero the counter reloads the current period.
// R11 - Software count write is immediate and beats count, clear and reload.
// R12 - Direction may change while running; new direction applies to later counts.
// R13 - Event up/down: event n enables counting, event n+1 selects direction; quadrature too.
// R14 - Low timer overflow event can clock a second, high timer.
// R15 - Unbuffered period write is immediate; counter below-top passes and wraps at maximum.
// R16 - Period buffer writable anytime; working period loads only on update.
// R17 - Software keeps normal operation whenever a channel captures.
// R18 - Event source selection maps to channel A, following channels to following events.
// R19 - On capture, each enabled channel stores the current count value.
// R20 - Period below 0x8000: captured msb holds edge polarity, one for rising; the code takes it from the channel A event level for every channel.
// R21 - Frequency capture: rising edge captures the count and restarts the counter.
// R22 - Pulse-width capture: rising edge restarts, falling edge captures; pin senses both edges.
// R23 - Update condition is raised at zero or at top, chosen by waveform mode.
// R24 - Count, period, period buffer, channel and channel buffer are sixteen bits.
// R25 - Software enables one channel only during frequency capture.
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

`define TCC_WIDTH 16
`define TCC_CHANNELS 4
`define TCC_EVENTS 8

`define TCC_SRC_OFF 4'h0
`define TCC_SRC_DIV1 4'h1
`define TCC_SRC_DIV1024 4'h7
`define TCC_SRC_EVENT0 4'h8

`define TCC_EVENT_ACTION_SELECT_OFF 3'h0
`define TCC_EVENT_ACTION_SELECT_CAPTURE 3'h1
`define TCC_EVENT_ACTION_SELECT_UPDOWN 3'h2
`define TCC_EVENT_ACTION_SELECT_QDEC 3'h3
`define TCC_EVENT_ACTION_SELECT_RESTART 3'h4
`define TCC_EVENT_ACTION_SELECT_FREQ 3'h5
`define TCC_EVENT_ACTION_SELECT_PULSE 3'h6

`define TCC_WG_NORMAL 3'h0
`define TCC_WG_FREQ 3'h1
`define TCC_WG_SINGLE 3'h3
`define TCC_WG_DUAL_TOP 3'h5
`define TCC_WG_DUAL_BOTH 3'h6
`define TCC_WG_DUAL_BOTTOM 3'h7

`define TCC_COUNT_RESET 16'h0000
`define TCC_PERIOD_RESET 16'hffff
`define TCC_MAX 16'hffff
`define TCC_POLARITY_LIMIT 16'h8000

`define TCC_PRESC_WIDTH 10

`endif

// ### logic/tcc_pkg.sv
// Types shared by the timer/counter files
`default_nettype none
`include "tcc_map.svh"
package tcc_pkg;
    typedef logic [`TCC_WIDTH-1:0] tcc_word_t; // R24
    typedef enum logic [2:0] {
        TCC_ACT_OFF = `TCC_EVENT_ACTION_SELECT_OFF,
        TCC_ACT_CAPTURE = `TCC_EVENT_ACTION_SELECT_CAPTURE,
        TCC_ACT_UPDOWN = `TCC_EVENT_ACTION_SELECT_UPDOWN,
        TCC_ACT_QDEC = `TCC_EVENT_ACTION_SELECT_QDEC,
        TCC_ACT_RESTART = `TCC_EVENT_ACTION_SELECT_RESTART,
        TCC_ACT_FREQ = `TCC_EVENT_ACTION_SELECT_FREQ,
        TCC_ACT_PULSE = `TCC_EVENT_ACTION_SELECT_PULSE
    } tcc_event_action_select_t;
endpackage
`default_nettype wire

// ### logic/tcc_prescaler.sv
// Shared peripheral clock prescaler with seven tap strobes
`timescale 1ns/10ps
`default_nettype none
`include "tcc_map.svh"
module tcc_prescaler (
    input wire logic clock_i,
    input wire logic resetn_i,
    output logic [6:0] tap_o
);
    logic [`TCC_PRESC_WIDTH-1:0] div_q;

    // A tap fires when its low bits are all ones
    function automatic logic tap_fire(input logic [`TCC_PRESC_WIDTH-1:0] cnt, input int bits);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < `TCC_PRESC_WIDTH; i++) begin
            if (i < bits && !cnt[i]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 10'h000;
        end else begin
            div_q <= div_q + 10'h001;
        end
    end

    // Divide by 1, 2, 4, 8, 64, 256, 1024
    always_comb begin
        tap_o[0] = 1'b1; // R1
        tap_o[1] = tap_fire(div_q, 1);
        tap_o[2] = tap_fire(div_q, 2);
        tap_o[3] = tap_fire(div_q, 3);
        tap_o[4] = tap_fire(div_q, 6);
        tap_o[5] = tap_fire(div_q, 8);
        tap_o[6] = tap_fire(div_q, 10); // R1
    end
endmodule // tcc_prescaler
`default_nettype wire

// ### logic/tcc_timer_counter_capture_core.sv
// Base counter with double-buffered period and four capture/compare channels
`timescale 1ns/10ps
`default_nettype none
`include "tcc_map.svh"
module tcc_timer_counter_capture_core (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [3:0] count_source_select_i,
    input wire logic [2:0] event_action_select_i,
    input wire logic [2:0] event_source_select_i,
    input wire logic [2:0] waveform_mode_i,
    input wire logic count_down_i,
    input wire logic [3:0] capture_enable_i,
    input wire logic [7:0] event_i,
    input wire logic [7:0] event_level_i,
    input wire logic [15:0] wdata_i,
    input wire logic count_value_wr_i,
    input wire logic period_wr_i,
    input wire logic period_buffer_wr_i,
    input wire logic [3:0] channel_wr_i,
    input wire logic [3:0] channel_buffer_wr_i,
    input wire logic [3:0] channel_rd_i,
    output logic [15:0] count_value_o,
    output logic [15:0] period_o,
    output logic [15:0] period_buffer_o,
    output logic period_valid_o,
    output logic [3:0][15:0] channel_register_o,
    output logic [3:0][15:0] channel_buffer_o,
    output logic [3:0] buffer_valid_flag_o,
    output logic [3:0] channel_flag_o,
    output logic [3:0] capture_error_o,
    output logic overflow_event_o,
    output logic underflow_event_o,
    output logic update_o,
    output logic direction_down_o
);
    tcc_pkg::tcc_word_t count_q;
    tcc_pkg::tcc_word_t count_d;
    tcc_pkg::tcc_word_t period_q;
    tcc_pkg::tcc_word_t period_buffer_q;
    logic period_valid_q;
    tcc_pkg::tcc_word_t [3:0] channel_q;
    tcc_pkg::tcc_word_t [3:0] channel_buffer_q;
    logic [3:0] buffer_valid_q;
    logic [3:0] channel_flag_q;
    logic [3:0] capture_error_q;
    logic overflow_q;
    logic underflow_q;
    logic update_q;
    logic [6:0] tap;
    logic source_tick;
    logic count_tick;
    logic dir_down;
    logic at_top;
    logic at_bottom;
    logic wrap_up;
    logic wrap_down;
    logic update_now;
    logic restart;
    logic capture_mode;
    logic [3:0] capture_hit;
    logic [3:0] capture_accept;
    logic [3:0] queue_move;
    tcc_pkg::tcc_word_t top_value;
    tcc_pkg::tcc_word_t stamp;
    tcc_pkg::tcc_event_action_select_t action;

    tcc_prescaler u_prescaler (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .tap_o(tap)
    );

    // Event channel index wraps round the eight channels
    function automatic logic event_at(input logic [7:0] ev, input logic [2:0] base, input logic [2:0] offs);
        logic [2:0] idx;
        idx = base + offs;
        return ev[idx];
    endfunction

    function automatic logic is_capture_action(input tcc_pkg::tcc_event_action_select_t act);
        return act == tcc_pkg::TCC_ACT_CAPTURE || act == tcc_pkg::TCC_ACT_FREQ || act == tcc_pkg::TCC_ACT_PULSE;
    endfunction

    function automatic logic update_at_bottom(input logic [2:0] mode);
        return mode == `TCC_WG_DUAL_TOP || mode == `TCC_WG_DUAL_BOTH || mode == `TCC_WG_DUAL_BOTTOM;
    endfunction

    assign action = tcc_pkg::tcc_event_action_select_t'(event_action_select_i);
    assign capture_mode = is_capture_action(action);

    // Source zero means stopped, so reset leaves the counter idle
    always_comb begin
        source_tick = 1'b0; // R4
        if (count_source_select_i >= `TCC_SRC_EVENT0) begin
            source_tick = event_i[count_source_select_i[2:0]]; // R2
        end else if (count_source_select_i >= `TCC_SRC_DIV1) begin
            source_tick = tap[count_source_select_i[2:0] - 3'h1]; // R1 R2
        end
    end

    // Event n gates counting, event n+1 level gives direction
    always_comb begin
        count_tick = source_tick;
        dir_down = count_down_i; // R12
        if (action == tcc_pkg::TCC_ACT_UPDOWN || action == tcc_pkg::TCC_ACT_QDEC) begin
            count_tick = source_tick & event_at(event_level_i, event_source_select_i, 3'h0); // R13
            dir_down = ~event_at(event_level_i, event_source_select_i, 3'h1); // R13
        end
    end

    // Frequency waveform mode takes its top from channel A
    assign top_value = (waveform_mode_i == `TCC_WG_FREQ) ? channel_q[0] : period_q;
    // Equality compare only: a top written below the count is passed and wraps at max
    assign at_top = (count_q == top_value) || (count_q == `TCC_MAX); // R15
    assign at_bottom = (count_q == `TCC_COUNT_RESET);
    assign wrap_up = count_tick && !dir_down && at_top;
    assign wrap_down = count_tick && dir_down && at_bottom;
    assign update_now = update_at_bottom(waveform_mode_i) ? wrap_down : (wrap_up | wrap_down); // R23

    // Restart on rising edge in frequency or pulse-width capture, or on plain restart action
    always_comb begin
        restart = 1'b0;
        for (int i = 0; i < `TCC_CHANNELS; i++) begin
            if (capture_enable_i[i] && event_at(event_i, event_source_select_i, 3'(i))
                && event_at(event_level_i, event_source_select_i, 3'(i))
                && (action == tcc_pkg::TCC_ACT_FREQ || action == tcc_pkg::TCC_ACT_PULSE)) begin
                restart = 1'b1; // R21 R22
            end
        end
        if (action == tcc_pkg::TCC_ACT_RESTART && event_at(event_i, event_source_select_i, 3'h0)) begin
            restart = 1'b1;
        end
    end

    // Which channels capture this cycle
    always_comb begin
        for (int i = 0; i < `TCC_CHANNELS; i++) begin
            capture_hit[i] = 1'b0;
            if (capture_mode && capture_enable_i[i] && event_at(event_i, event_source_select_i, 3'(i))) begin // R18
                case (action)
                    tcc_pkg::TCC_ACT_CAPTURE: capture_hit[i] = 1'b1; // R19
                    tcc_pkg::TCC_ACT_FREQ: capture_hit[i] = event_at(event_level_i, event_source_select_i, 3'(i)); // R21
                    tcc_pkg::TCC_ACT_PULSE: capture_hit[i] = ~event_at(event_level_i, event_source_select_i, 3'(i)); // R22
                    default: capture_hit[i] = 1'b0;
                endcase
            end
        end
    end

    // Both queue slots full means nowhere to put the new stamp
    always_comb begin
        for (int i = 0; i < `TCC_CHANNELS; i++) begin
            capture_accept[i] = capture_hit[i] && !(buffer_valid_q[i] && channel_flag_q[i]);
            queue_move[i] = capture_mode && buffer_valid_q[i] && (!channel_flag_q[i] || channel_rd_i[i]); // R7
        end
    end

    // The channel A event level rides in every stamp's msb only while the period leaves it unused
    always_comb begin
        stamp = count_q; // R19
        if (period_q < `TCC_POLARITY_LIMIT) begin
            stamp[`TCC_WIDTH-1] = event_at(event_level_i, event_source_select_i, 3'h0); // R20
        end
    end

    // Software write first, then restart, then clear, reload or count
    always_comb begin
        count_d = count_q;
        if (count_value_wr_i) begin
            count_d = wdata_i; // R11
        end else if (restart) begin
            count_d = `TCC_COUNT_RESET;
        end else if (wrap_up) begin
            count_d = `TCC_COUNT_RESET; // R9
        end else if (wrap_down) begin
            count_d = period_q; // R10
        end else if (count_tick) begin
            count_d = dir_down ? count_q - 16'h0001 : count_q + 16'h0001;
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_q <= `TCC_COUNT_RESET;
        end else begin
            count_q <= count_d;
        end
    end

    // Working period: direct write is immediate, buffer copies on update
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_q <= `TCC_PERIOD_RESET;
        end else if (period_wr_i) begin
            period_q <= wdata_i; // R15
        end else if (update_now && period_valid_q) begin
            period_q <= period_buffer_q; // R16
        end
    end

    // A buffer write in the update cycle keeps the flag set
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            period_buffer_q <= `TCC_PERIOD_RESET;
            period_valid_q <= 1'b0;
        end else if (period_buffer_wr_i) begin
            period_buffer_q <= wdata_i; // R16
            period_valid_q <= 1'b1; // R5
        end else if (update_now) begin
            period_valid_q <= 1'b0; // R5
        end
    end

    // Channel buffers and their valid flags
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_buffer_q <= '0;
            buffer_valid_q <= 4'h0;
        end else begin
            for (int i = 0; i < `TCC_CHANNELS; i++) begin
                if (channel_buffer_wr_i[i]) begin
                    channel_buffer_q[i] <= wdata_i; // R8
                    if (!capture_mode) begin
                        buffer_valid_q[i] <= 1'b1; // R5
                    end
                end else if (capture_accept[i] && (!buffer_valid_q[i] || queue_move[i])) begin
                    channel_buffer_q[i] <= stamp;
                    buffer_valid_q[i] <= 1'b1; // R6
                end else if (capture_mode ? queue_move[i] : update_now) begin
                    buffer_valid_q[i] <= 1'b0; // R5 R7
                end
            end
        end
    end

    // Channel registers: direct write, compare update, or queue advance
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_q <= '0;
        end else begin
            for (int i = 0; i < `TCC_CHANNELS; i++) begin
                if (channel_wr_i[i]) begin
                    channel_q[i] <= wdata_i; // R8
                end else if (capture_mode ? queue_move[i] : (update_now && buffer_valid_q[i])) begin
                    channel_q[i] <= channel_buffer_q[i]; // R5 R7
                end
            end
        end
    end

    // Channel flag: set by queue advance wins over clear by read
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            channel_flag_q <= 4'h0;
        end else begin
            for (int i = 0; i < `TCC_CHANNELS; i++) begin
                if (queue_move[i]) begin
                    channel_flag_q[i] <= 1'b1; // R7
                end else if (channel_rd_i[i] || channel_wr_i[i]) begin
                    channel_flag_q[i] <= 1'b0;
                end
            end
        end
    end

    // Rejected stamps leave a sticky error until the register is read
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            capture_error_q <= 4'h0;
        end else begin
            for (int i = 0; i < `TCC_CHANNELS; i++) begin
                if (capture_hit[i] && !capture_accept[i]) begin
                    capture_error_q[i] <= 1'b1;
                end else if (channel_rd_i[i]) begin
                    capture_error_q[i] <= 1'b0;
                end
            end
        end
    end

    // Overflow pulse is the event a cascaded high timer counts
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            overflow_q <= 1'b0;
            underflow_q <= 1'b0;
            update_q <= 1'b0;
        end else begin
            overflow_q <= wrap_up && !count_value_wr_i && !restart; // R14
            underflow_q <= wrap_down && !count_value_wr_i && !restart;
            update_q <= update_now;
        end
    end

    assign count_value_o = count_q;
    assign period_o = period_q;
    assign period_buffer_o = period_buffer_q;
    assign period_valid_o = period_valid_q;
    assign channel_register_o = channel_q;
    assign channel_buffer_o = channel_buffer_q;
    assign buffer_valid_flag_o = buffer_valid_q;
    assign channel_flag_o = channel_flag_q;
    assign capture_error_o = capture_error_q;
    assign overflow_event_o = overflow_q;
    assign underflow_event_o = underflow_q;
    assign update_o = update_q;
    assign direction_down_o = dir_down;
endmodule // tcc_timer_counter_capture_core
`default_nettype wire

// ### verif/tcc_core_sva.sv
// Checker for the timer/counter base counter and capture channels
`timescale 1ns/10ps
`default_nettype none
module tcc_core_sva (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic [3:0] count_source_select_i,
    input wire logic [2:0] event_action_select_i,
    input wire logic [2:0] event_source_select_i,
    input wire logic count_down_i,
    input wire logic [3:0] capture_enable_i,
    input wire logic [7:0] event_i,
    input wire logic [15:0] wdata_i,
    input wire logic count_value_wr_i,
    input wire logic period_wr_i,
    input wire logic period_buffer_wr_i,
    input wire logic [3:0] channel_wr_i,
    input wire logic [3:0] channel_buffer_wr_i,
    input wire logic [15:0] count_value_o,
    input wire logic [15:0] period_o,
    input wire logic period_valid_o,
    input wire logic [3:0][15:0] channel_register_o,
    input wire logic [3:0][15:0] channel_buffer_o,
    input wire logic [3:0] buffer_valid_flag_o,
    input wire logic [3:0] channel_flag_o,
    input wire logic overflow_event_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    // Plain counting from the undivided tap, no event action in play
    logic run_up;
    assign run_up = count_source_select_i == 4'h1 && event_action_select_i == 3'h0 && !count_value_wr_i;
    a_idle_no_source: assert property (count_source_select_i == 4'h0 && event_action_select_i == 3'h0 &&
        !count_value_wr_i |=> $stable(count_value_o)) else $error("idle count moved");
    a_up_wrap_zero: assert property (run_up && !count_down_i && count_value_o == period_o
        |=> count_value_o == 16'h0000 && overflow_event_o) else $error("no wrap to zero at top");
    a_down_reload: assert property (run_up && count_down_i && count_value_o == 16'h0000
        |=> count_value_o == $past(period_o)) else $error("no reload at bottom");
    a_up_step: assert property (run_up && !count_down_i && count_value_o != period_o &&
        count_value_o != 16'hffff |=> count_value_o == $past(count_value_o) + 16'h0001) else $error("bad up step");
    a_write_wins: assert property (count_value_wr_i |=> count_value_o == $past(wdata_i))
        else $error("count write lost");
    a_period_now: assert property (period_wr_i |=> period_o == $past(wdata_i)) else $error("period write late");
    a_period_valid: assert property (period_buffer_wr_i |=> period_valid_o) else $error("period valid not set");
    a_period_hold: assert property (!period_wr_i && !period_valid_o |=> $stable(period_o))
        else $error("period moved");
    a_chan_direct: assert property (channel_wr_i[1] |=> channel_register_o[1] == $past(wdata_i))
        else $error("direct channel write lost");
    a_capture_stamp: assert property (event_action_select_i == 3'h1 && capture_enable_i[1] &&
        event_i[event_source_select_i + 3'h1] && !buffer_valid_flag_o[1] && !channel_buffer_wr_i[1]
        |=> buffer_valid_flag_o[1] && channel_buffer_o[1][14:0] == $past(count_value_o[14:0]))
        else $error("capture stamp wrong");
    a_queue_move: assert property (event_action_select_i == 3'h1 && buffer_valid_flag_o[1] &&
        !channel_flag_o[1] && channel_wr_i == 4'h0 && channel_buffer_wr_i == 4'h0
        |=> channel_flag_o[1] && channel_register_o[1] == $past(channel_buffer_o[1])) else $error("queue move wrong");
    c_overflow: cover property (overflow_event_o);
    c_period_update: cover property ($fell(period_valid_o));
    c_capture_flag: cover property ($rose(channel_flag_o[1]));
endmodule // tcc_core_sva
bind tcc_timer_counter_capture_core tcc_core_sva u_sva (.clock_i, .resetn_i, .count_source_select_i,
    .event_action_select_i, .event_source_select_i, .count_down_i, .capture_enable_i, .event_i, .wdata_i,
    .count_value_wr_i, .period_wr_i, .period_buffer_wr_i, .channel_wr_i, .channel_buffer_wr_i, .count_value_o,
    .period_o, .period_valid_o, .channel_register_o, .channel_buffer_o, .buffer_valid_flag_o, .channel_flag_o,
    .overflow_event_o);
`default_nettype wire

// ### verif/tcc_event_net.sv
// Event routing network model feeding the timer's event channels
`timescale 1ns/10ps
`default_nettype none
module tcc_event_net (
    input wire logic [7:0] pulse_i,
    input wire logic [7:0] level_i,
    input wire logic overflow_i,
    input wire logic route_i,
    output logic [7:0] event_o,
    output logic [7:0] level_o
);
    // Overflow of a low timer may be routed to channel 7 to clock a high timer
    assign event_o = pulse_i | {route_i & overflow_i, 7'h00};
    // Pin levels pass straight through; sensing both edges is a pin setting
    assign level_o = level_i;
endmodule // tcc_event_net
`default_nettype wire

// ### verif/test_tcc_timer_counter_capture_core.sv
// Self-checking bench for the timer/counter base counter and capture channels
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_tcc_timer_counter_capture_core;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [3:0] src = 4'h0, cap_en = 4'h0, ch_wr = 4'h0, chb_wr = 4'h0, ch_rd = 4'h0;
    logic [2:0] act = 3'h0, esel = 3'h0, wave = 3'h0;
    logic down = 1'b0, cnt_wr = 1'b0, per_wr = 1'b0, pbuf_wr = 1'b0, route = 1'b0;
    logic [7:0] pulse = 8'h00, lvl = 8'h00, ev_w, lvl_w;
    logic [15:0] wdata = 16'h0000, cnt, per, pbuf;
    logic pval, ovf, unf, upd, dir;
    logic [3:0][15:0] chreg, chbuf;
    logic [3:0] bv, flag, err;
    int fail_count = 0, check_count = 0, cycles = 0;
    int divs [1:7] = '{1, 2, 4, 8, 64, 256, 1024};
    always #20 clock_i = ~clock_i;
    tcc_event_net u_net (.pulse_i(pulse), .level_i(lvl), .overflow_i(ovf), .route_i(route),
        .event_o(ev_w), .level_o(lvl_w));
    tcc_timer_counter_capture_core uut (.clock_i(clock_i), .resetn_i(resetn_i), .count_source_select_i(src),
        .event_action_select_i(act), .event_source_select_i(esel), .waveform_mode_i(wave), .count_down_i(down),
        .capture_enable_i(cap_en), .event_i(ev_w), .event_level_i(lvl_w), .wdata_i(wdata),
        .count_value_wr_i(cnt_wr), .period_wr_i(per_wr), .period_buffer_wr_i(pbuf_wr), .channel_wr_i(ch_wr),
        .channel_buffer_wr_i(chb_wr), .channel_rd_i(ch_rd), .count_value_o(cnt), .period_o(per),
        .period_buffer_o(pbuf), .period_valid_o(pval), .channel_register_o(chreg), .channel_buffer_o(chbuf),
        .buffer_valid_flag_o(bv), .channel_flag_o(flag), .capture_error_o(err), .overflow_event_o(ovf),
        .underflow_event_o(unf), .update_o(upd), .direction_down_o(dir));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    // Kind 0 count, 1 period, 2 period buffer; strobe stands one edge
    task automatic wr(input int kind, input logic [15:0] v);
        wdata = v;
        cnt_wr = (kind == 0);
        per_wr = (kind == 1);
        pbuf_wr = (kind == 2);
        @(posedge clock_i) {cnt_wr, per_wr, pbuf_wr} <= 3'h0;
        #1;
    endtask
    task automatic ev(input int ch);
        pulse[ch] = 1'b1;
        @(posedge clock_i) pulse <= 8'h00;
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Ceiling well above the ~5500 cycles the sequence needs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (20) @(posedge clock_i);
        #1 resetn_i = 1'b1;
        `CHK("period", 16'hffff, per)
        `CHK("period buffer", 16'hffff, pbuf)
        cyc(3);
        `CHK("idle count", 16'h0000, cnt)
        wr(1, 16'h0002);
        `CHK("period", 16'h0002, per)
        src = 4'h1;
        cyc(2);
        `CHK("count", 16'h0002, cnt)
        cyc(1);
        `CHK("count", 16'h0000, cnt)
        `CHK("overflow", 1'b1, ovf)
        `CHK("update", 1'b1, upd)
        wr(0, 16'h0005);
        `CHK("count", 16'h0005, cnt)
        cyc(1);
        `CHK("past top", 16'h0006, cnt)
        wr(0, 16'hffff);
        `CHK("count", 16'hffff, cnt)
        cyc(1);
        `CHK("count", 16'h0000, cnt)
        down = 1'b1;
        cyc(1);
        `CHK("reload", 16'h0002, cnt)
        `CHK("underflow", 1'b1, unf)
        down = 1'b0;
        cyc(1);
        `CHK("direction", 16'h0000, cnt)
        src = 4'h0;
        wr(1, 16'hffff);
        for (int i = 1; i <= 7; i++) begin
            wr(0, 16'h0000);
            src = 4'(i);
            cyc(4 * divs[i]);
            src = 4'h0;
            `CHK("tap count", 16'h0004, cnt)
        end
        wr(1, 16'h0003);
        wr(0, 16'h0000);
        wr(2, 16'h0001);
        `CHK("period valid", 1'b1, pval)
        `CHK("period", 16'h0003, per)
        wdata = 16'h1234;
        chb_wr = 4'h1;
        cyc(1);
        chb_wr = 4'h0;
        `CHK("buffer valid", 1'b1, bv[0])
        wdata = 16'habcd;
        ch_wr = 4'h2;
        cyc(1);
        ch_wr = 4'h0;
        `CHK("channel 1", 16'habcd, chreg[1])
        src = 4'h1;
        cyc(4);
        src = 4'h0;
        cyc(1);
        `CHK("period", 16'h0001, per)
        `CHK("period valid", 1'b0, pval)
        `CHK("channel 0", 16'h1234, chreg[0])
        `CHK("buffer valid", 1'b0, bv[0])
        // Capture runs with the counter in normal operation
        wr(1, 16'h0100);
        act = 3'h1;
        esel = 3'h2;
        cap_en = 4'h2;
        wr(0, 16'h0010);
        lvl = 8'hff;
        ev(3);
        `CHK("stamp", 16'h8010, chbuf[1])
        `CHK("buffer valid", 1'b1, bv[1])
        cyc(1);
        `CHK("channel 1", 16'h8010, chreg[1])
        `CHK("flag", 1'b1, flag[1])
        wr(0, 16'h0020);
        lvl = 8'h00;
        ev(3);
        cyc(1);
        `CHK("stamp", 16'h0020, chbuf[1])
        `CHK("buffer held", 1'b1, bv[1])
        ev(3);
        `CHK("overrun", 1'b1, err[1])
        ch_rd = 4'h2;
        cyc(1);
        ch_rd = 4'h0;
        `CHK("channel 1", 16'h0020, chreg[1])
        `CHK("buffer valid", 1'b0, bv[1])
        // One channel only while frequency capture runs
        cap_en = 4'h1;
        act = 3'h5;
        wdata = 16'h0000;
        ch_wr = 4'h1;
        cyc(1);
        ch_wr = 4'h0;
        wr(0, 16'h0033);
        lvl = 8'hff;
        ev(2);
        `CHK("stamp", 16'h8033, chbuf[0])
        cyc(1);
        `CHK("restart", 16'h0000, cnt)
        `CHK("channel 0", 16'h8033, chreg[0])
        act = 3'h6;
        ch_rd = 4'h1;
        cyc(1);
        ch_rd = 4'h0;
        wr(0, 16'h0044);
        ev(2);
        cyc(1);
        `CHK("restart", 16'h0000, cnt)
        `CHK("no capture", 1'b0, bv[0])
        wr(0, 16'h0055);
        lvl = 8'h00;
        ev(2);
        `CHK("stamp", 16'h0055, chbuf[0])
        // Event action counting takes its clock from an event channel
        act = 3'h2;
        esel = 3'h4;
        src = 4'hc;
        wr(0, 16'h0010);
        lvl = 8'h30;
        ev(4);
        `CHK("event up", 16'h0011, cnt)
        lvl = 8'h10;
        ev(4);
        `CHK("event down", 16'h0010, cnt)
        `CHK("direction", 1'b1, dir)
        lvl = 8'h20;
        ev(4);
        `CHK("no enable", 16'h0010, cnt)
        act = 3'h3;
        lvl = 8'h30;
        ev(4);
        `CHK("quadrature", 16'h0011, cnt)
        act = 3'h0;
        ev(4);
        `CHK("event source", 16'h0012, cnt)
        route = 1'b1;
        src = 4'hf;
        wr(0, 16'hffff);
        ev(7);
        cyc(1);
        `CHK("cascade", 16'h0001, cnt)
        finish_test();
    end
endmodule // test_tcc_timer_counter_capture_core
`default_nettype wire
